// File: rtl/pcpl_params.svh
`ifndef PCPL_PARAMS_SVH
`define PCPL_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets on the AXI4-Lite slave
// ----------------------------------------------------------------------------
`define PCPL_REG_LOW        8'h00
`define PCPL_REG_LATCH      8'h04
`define PCPL_REG_PC         8'h08
`define PCPL_REG_CTRL       8'h0C

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define PCPL_CTRL_RUN_BIT   0
`define PCPL_CTRL_RESET     1'b1
`define PCPL_PC_RESET       16'h0000
`define PCPL_LATCH_RESET    8'h00
`define PCPL_IRQ_VECTOR     16'h0020
`define PCPL_PC_SP_LSB      16

// ----------------------------------------------------------------------------
// Timing: clock cycles per instruction cycle (four phases), and return stack depth
// ----------------------------------------------------------------------------
`define PCPL_PHASES         4
`define PCPL_STACK_DEPTH    16

// ----------------------------------------------------------------------------
// AXI response codes
// ----------------------------------------------------------------------------
`define PCPL_RESP_OKAY      2'b00
`define PCPL_RESP_SLVERR    2'b10

`endif

// File: rtl/pcpl_pkg.sv
package pcpl_pkg;

	// Operations handed over by the instruction decoder
	typedef enum logic [3:0] {
		PCPL_OP_SEQ      = 4'h0,
		PCPL_OP_SKIP     = 4'h1,
		PCPL_OP_JUMP     = 4'h2,
		PCPL_OP_CALL     = 4'h3,
		PCPL_OP_LONG_CALL = 4'h4,
		PCPL_OP_RETURN   = 4'h5,
		PCPL_OP_RET_LIT  = 4'h6,
		PCPL_OP_RET_IRQ  = 4'h7,
		PCPL_OP_IRQ      = 4'h8,
		PCPL_OP_READ_LOW = 4'h9,
		PCPL_OP_WRITE_LOW = 4'hA,
		PCPL_OP_RMW_LOW  = 4'hB
	} pcpl_op_t;

	// One decoder command per instruction cycle
	typedef struct packed {
		pcpl_op_t    op;
		logic [15:0] opcode;
		logic [7:0]  bus_data;
	} pcpl_cmd_t;

	// Register slave sequencing, one-hot
	typedef enum logic [2:0] {
		PCPL_AX_IDLE  = 3'b001,
		PCPL_AX_WRESP = 3'b010,
		PCPL_AX_RRESP = 3'b100
	} pcpl_ax_state_t;

	// Decoded register select
	typedef enum logic [2:0] {
		PCPL_SEL_LOW   = 3'd0,
		PCPL_SEL_LATCH = 3'd1,
		PCPL_SEL_PC    = 3'd2,
		PCPL_SEL_CTRL  = 3'd3,
		PCPL_SEL_NONE  = 3'd4
	} pcpl_sel_t;

endpackage

// File: rtl/pcpl_program_counter.sv
`timescale 1ns/100ps
`include "pcpl_params.svh"

module pcpl_program_counter
	import pcpl_pkg::*;
#(
	parameter int          ADDR_W      = 8,
	parameter int          STACK_DEPTH = `PCPL_STACK_DEPTH,
	parameter logic [15:0] IRQ_VECTOR  = `PCPL_IRQ_VECTOR
) (
	input  wire logic              clock_i,
	input  wire logic              rst_i,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Instruction decoder side
	input  wire logic              cmd_valid_i,
	input  wire pcpl_cmd_t         cmd_i,
	output logic                   cmd_ready_o,
	output logic [15:0]            pc_o,
	output logic [7:0]             high_byte_holding_latch_o,
	output logic [7:0]             low_read_data_o,
	output logic                   first_cycle_phase_o
);

	localparam int SPW = $clog2(STACK_DEPTH);

	// ------------------------------------------------------------------------
	// Address decode, shared by read and write paths
	// ------------------------------------------------------------------------
	function automatic pcpl_sel_t decode_sel(input logic [ADDR_W-1:0] addr);
		pcpl_sel_t sel;
		case (addr)
			ADDR_W'(`PCPL_REG_LOW): sel = PCPL_SEL_LOW;
			ADDR_W'(`PCPL_REG_LATCH): sel = PCPL_SEL_LATCH;
			ADDR_W'(`PCPL_REG_PC): sel = PCPL_SEL_PC;
			ADDR_W'(`PCPL_REG_CTRL): sel = PCPL_SEL_CTRL;
			default: sel = PCPL_SEL_NONE;
		endcase
		return sel;
	endfunction

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	logic [15:0]       pc;
	logic [7:0]        latch;
	logic [7:0]        low_rd;
	logic [SPW-1:0]    sp;
	logic              run;
	logic [1:0]        phase;
	logic [15:0]       next_pc;
	logic [7:0]        next_latch;
	logic [7:0]        next_low_rd;
	logic [SPW-1:0]    next_sp;
	logic              next_run;
	logic [1:0]        next_phase;

	pcpl_ax_state_t    ax_state;
	pcpl_ax_state_t    next_ax_state;
	logic              aw_held;
	logic              w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;
	logic [1:0]        bresp;
	logic [31:0]       rdata;
	logic [1:0]        rresp;
	logic              next_aw_held;
	logic              next_w_held;
	logic [ADDR_W-1:0] next_aw_addr;
	logic [31:0]       next_w_data;
	logic [3:0]        next_w_strb;
	logic [1:0]        next_bresp;
	logic [31:0]       next_rdata;
	logic [1:0]        next_rresp;

	logic              fetch_ph;
	logic              take_cmd;
	logic              do_write;
	logic              do_read;
	logic              push;
	logic [15:0]       tos;
	pcpl_sel_t         wsel;
	pcpl_sel_t         rsel;

	// ------------------------------------------------------------------------
	// Return stack
	// ------------------------------------------------------------------------
	// Ring of fixed depth: overflow silently overwrites the oldest entry
	pcpl_stack #(
		.DEPTH (STACK_DEPTH),
		.WIDTH (16)
	) u_stack (
		.clock_i   (clock_i),
		.wr_en_i   (push),
		.wr_addr_i (sp),
		.wr_data_i (pc),
		.rd_addr_i (SPW'(sp - SPW'(1))),
		.rd_data_o (tos)
	);

	// ------------------------------------------------------------------------
	// Phase strobes and access arbitration
	// ------------------------------------------------------------------------
	// Decoder owns the first phase; register accesses wait for other phases
	assign fetch_ph      = run && (phase == 2'd0);
	assign cmd_ready_o   = fetch_ph;
	assign take_cmd      = fetch_ph && cmd_valid_i;
	assign wsel          = decode_sel(aw_addr);
	assign rsel          = decode_sel(s_axi_araddr);
	assign do_write      = (ax_state == PCPL_AX_IDLE) && aw_held && w_held && !fetch_ph;
	assign do_read       = (ax_state == PCPL_AX_IDLE) && !(aw_held && w_held)
		&& s_axi_arvalid && !fetch_ph;
	assign push          = take_cmd && (cmd_i.op == PCPL_OP_CALL
		|| cmd_i.op == PCPL_OP_LONG_CALL || cmd_i.op == PCPL_OP_IRQ);

	// ------------------------------------------------------------------------
	// Counter, latch and stack pointer next values
	// ------------------------------------------------------------------------
	always_comb begin
		next_pc     = pc;
		next_latch  = latch;
		next_low_rd = low_rd;
		next_sp     = sp;
		next_run    = run;
		next_phase  = run ? 2'(phase + 2'd1) : 2'd0;
		if (take_cmd) begin
			case (cmd_i.op)
				PCPL_OP_SEQ: begin
					next_pc = 16'(pc + 16'd1);
				end
				PCPL_OP_SKIP: begin
					next_pc = 16'(pc + 16'd1);
				end
				PCPL_OP_JUMP, PCPL_OP_CALL: begin
					next_pc    = {pc[15:13], cmd_i.opcode[12:0]};
					next_latch = {pc[15:13], cmd_i.opcode[12:8]};
					if (cmd_i.op == PCPL_OP_CALL) begin
						next_sp = SPW'(sp + SPW'(1));
					end
				end
				PCPL_OP_LONG_CALL: begin
					next_pc = {latch, cmd_i.opcode[7:0]};
					next_sp = SPW'(sp + SPW'(1));
				end
				PCPL_OP_RETURN: begin
					next_latch = pc[15:8];
					next_pc    = tos;
					next_sp    = SPW'(sp - SPW'(1));
				end
				PCPL_OP_RET_LIT, PCPL_OP_RET_IRQ: begin
					next_pc = tos;
					next_sp = SPW'(sp - SPW'(1));
				end
				PCPL_OP_IRQ: begin
					next_pc = IRQ_VECTOR;
					next_sp = SPW'(sp + SPW'(1));
				end
				PCPL_OP_READ_LOW: begin
					next_low_rd = pc[7:0];
					next_latch  = pc[15:8];
					next_pc     = 16'(pc + 16'd1);
				end
				PCPL_OP_WRITE_LOW: begin
					next_pc = {latch, cmd_i.bus_data};
				end
				PCPL_OP_RMW_LOW: begin
					next_low_rd = pc[7:0];
					next_pc     = {latch, cmd_i.bus_data};
				end
				default: begin
					next_pc = 16'(pc + 16'd1);
				end
			endcase
		end
		// Software path: same low byte and latch semantics as the data bus
		if (do_write && w_strb[0]) begin
			case (wsel)
				PCPL_SEL_LOW: next_pc = {latch, w_data[7:0]};
				PCPL_SEL_LATCH: next_latch = w_data[7:0];
				PCPL_SEL_CTRL: next_run = w_data[`PCPL_CTRL_RUN_BIT];
				default: next_run = run;
			endcase
		end
		if (do_read && rsel == PCPL_SEL_LOW) begin
			next_latch = pc[15:8];
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pc     <= `PCPL_PC_RESET;
			latch  <= `PCPL_LATCH_RESET;
			low_rd <= 8'h00;
			sp     <= '0;
			run    <= `PCPL_CTRL_RESET;
			phase  <= 2'd0;
		end else begin
			pc     <= next_pc;
			latch  <= next_latch;
			low_rd <= next_low_rd;
			sp     <= next_sp;
			run    <= next_run;
			phase  <= next_phase;
		end
	end

	// ------------------------------------------------------------------------
	// AXI4-Lite slave next values
	// ------------------------------------------------------------------------
	// One access at a time; a held write wins over a read offered in the same cycle
	always_comb begin
		next_ax_state = ax_state;
		next_aw_held  = aw_held;
		next_w_held   = w_held;
		next_aw_addr  = aw_addr;
		next_w_data   = w_data;
		next_w_strb   = w_strb;
		next_bresp    = bresp;
		next_rdata    = rdata;
		next_rresp    = rresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		case (ax_state)
			PCPL_AX_IDLE: begin
				if (do_write) begin
					next_aw_held  = 1'b0;
					next_w_held   = 1'b0;
					next_bresp    = (wsel == PCPL_SEL_NONE) ? `PCPL_RESP_SLVERR
						: `PCPL_RESP_OKAY;
					next_ax_state = PCPL_AX_WRESP;
				end else if (do_read) begin
					next_rresp    = `PCPL_RESP_OKAY;
					case (rsel)
						PCPL_SEL_LOW: next_rdata = {24'h000000, pc[7:0]};
						PCPL_SEL_LATCH: next_rdata = {24'h000000, latch};
						PCPL_SEL_PC: next_rdata = {{(16 - SPW){1'b0}}, sp, pc};
						PCPL_SEL_CTRL: next_rdata = {31'h00000000, run};
						default: begin
							next_rdata = 32'h00000000;
							next_rresp = `PCPL_RESP_SLVERR;
						end
					endcase
					next_ax_state = PCPL_AX_RRESP;
				end
			end
			PCPL_AX_WRESP: begin
				if (s_axi_bready) begin
					next_ax_state = PCPL_AX_IDLE;
				end
			end
			PCPL_AX_RRESP: begin
				if (s_axi_rready) begin
					next_ax_state = PCPL_AX_IDLE;
				end
			end
			default: begin
				next_ax_state = PCPL_AX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ax_state <= PCPL_AX_IDLE;
			aw_held  <= 1'b0;
			w_held   <= 1'b0;
			aw_addr  <= '0;
			w_data   <= 32'h00000000;
			w_strb   <= 4'h0;
			bresp    <= `PCPL_RESP_OKAY;
			rdata    <= 32'h00000000;
			rresp    <= `PCPL_RESP_OKAY;
		end else begin
			ax_state <= next_ax_state;
			aw_held  <= next_aw_held;
			w_held   <= next_w_held;
			aw_addr  <= next_aw_addr;
			w_data   <= next_w_data;
			w_strb   <= next_w_strb;
			bresp    <= next_bresp;
			rdata    <= next_rdata;
			rresp    <= next_rresp;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign s_axi_awready             = !aw_held && (ax_state == PCPL_AX_IDLE);
	assign s_axi_wready              = !w_held && (ax_state == PCPL_AX_IDLE);
	assign s_axi_arready             = do_read;
	assign s_axi_bvalid              = (ax_state == PCPL_AX_WRESP);
	assign s_axi_bresp               = bresp;
	assign s_axi_rvalid              = (ax_state == PCPL_AX_RRESP);
	assign s_axi_rdata               = rdata;
	assign s_axi_rresp               = rresp;
	assign pc_o                      = pc;
	assign high_byte_holding_latch_o = latch;
	assign low_read_data_o           = low_rd;
	assign first_cycle_phase_o       = fetch_ph;

endmodule

// File: rtl/pcpl_stack.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// Return address memory, registered read port
// ----------------------------------------------------------------------------
module pcpl_stack #(
	parameter int DEPTH = 16,
	parameter int WIDTH = 16,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             clock_i,
	input  wire logic             wr_en_i,
	input  wire logic [AW-1:0]    wr_addr_i,
	input  wire logic [WIDTH-1:0] wr_data_i,
	input  wire logic [AW-1:0]    rd_addr_i,
	output logic      [WIDTH-1:0] rd_data_o
);

	logic [WIDTH-1:0] mem [DEPTH];

	// Write and registered read; a read of the word being written sees old data
	always_ff @(posedge clock_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
		rd_data_o <= mem[rd_addr_i];
	end

endmodule

// File: verification/pcpl_asserts.sv
`timescale 1ns/100ps
module pcpl_asserts
	import pcpl_pkg::*;
#(
	parameter logic [15:0] IRQ_VECTOR = 16'h0020
) (
	input wire logic        clock_i,
	input wire logic        rst_i,
	input wire logic        cmd_valid_i,
	input wire pcpl_cmd_t   cmd_i,
	input wire logic        cmd_ready_o,
	input wire logic [15:0] pc_o,
	input wire logic [7:0]  high_byte_holding_latch_o,
	input wire logic [7:0]  low_read_data_o,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready
);
	// ------
	// Counter updates per taken command
	// ------
	wire logic [7:0] lat = high_byte_holding_latch_o;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	sequence take_s(pcpl_op_t k);
		cmd_ready_o && cmd_valid_i && cmd_i.op == k;
	endsequence
	seq_step_a: assert property (take_s(PCPL_OP_SEQ) |=> pc_o == $past(pc_o) + 16'h0001)
		else $error("counter did not advance");
	skip_nop_a: assert property (take_s(PCPL_OP_SKIP) |=> pc_o == $past(pc_o) + 16'h0001
		&& $stable(lat)) else $error("skip not a plain step");
	jump_load_a: assert property ((take_s(PCPL_OP_JUMP) or take_s(PCPL_OP_CALL))
		|=> pc_o == {$past(pc_o[15:13]), $past(cmd_i.opcode[12:0])}
		&& lat == {$past(pc_o[15:13]), $past(cmd_i.opcode[12:8])}) else $error("jump load wrong");
	long_call_a: assert property (take_s(PCPL_OP_LONG_CALL) |=> $stable(lat)
		&& pc_o == {$past(lat), $past(cmd_i.opcode[7:0])}) else $error("long call wrong");
	low_read_a: assert property (take_s(PCPL_OP_READ_LOW) |=> lat == $past(pc_o[15:8])
		&& low_read_data_o == $past(pc_o[7:0])) else $error("low read wrong");
	low_write_a: assert property (take_s(PCPL_OP_WRITE_LOW)
		|=> pc_o == {$past(lat), $past(cmd_i.bus_data)}) else $error("low write wrong");
	rmw_page_a: assert property (take_s(PCPL_OP_RMW_LOW) |=> $stable(lat)
		&& pc_o == {$past(lat), $past(cmd_i.bus_data)}) else $error("page jump wrong");
	ret_save_a: assert property (take_s(PCPL_OP_RETURN) |=> lat == $past(pc_o[15:8]))
		else $error("return latch wrong");
	ret_keep_a: assert property ((take_s(PCPL_OP_RET_LIT) or take_s(PCPL_OP_RET_IRQ))
		|=> $stable(lat)) else $error("latch disturbed");
	irq_vector_a: assert property (take_s(PCPL_OP_IRQ) |=> pc_o == IRQ_VECTOR
		&& $stable(lat)) else $error("vector not loaded");
	// Ready sits high through reset; skip the edge that releases it
	phase_gap_a: assert property (cmd_ready_o && !$past(rst_i) |=> !cmd_ready_o [*3])
		else $error("fetch phase too close");
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	resp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
endmodule

bind pcpl_program_counter pcpl_asserts #(.IRQ_VECTOR(IRQ_VECTOR)) chk_u (
	.clock_i(clock_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
	.cmd_ready_o(cmd_ready_o), .pc_o(pc_o), .low_read_data_o(low_read_data_o),
	.high_byte_holding_latch_o(high_byte_holding_latch_o),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));

// File: verification/pcpl_decoder_model.sv
`timescale 1ns/100ps
module pcpl_decoder_model
	import pcpl_pkg::*;
(
	input  wire logic      clock_i,
	input  wire logic      rst_i,
	input  wire logic      req_i,
	input  wire pcpl_cmd_t req_cmd_i,
	input  wire logic      cmd_ready_i,
	output logic           cmd_valid_o,
	output pcpl_cmd_t      cmd_o,
	output logic           done_o
);
	pcpl_cmd_t held;
	// Offer a command until a fetch phase takes it
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			cmd_valid_o <= 1'b0;
			done_o      <= 1'b0;
			held        <= '0;
		end else begin
			done_o <= cmd_valid_o && cmd_ready_i;
			if (cmd_valid_o && cmd_ready_i)
				cmd_valid_o <= 1'b0;
			if (req_i) begin
				held        <= req_cmd_i;
				cmd_valid_o <= 1'b1;
			end
		end
	end
	// Idle bus shows inverted bits, so a stale command never looks valid
	assign cmd_o = cmd_valid_o ? held : ~held;
endmodule

// File: verification/tb_top.sv
`timescale 1ns/100ps
`include "pcpl_params.svh"
module tb_top
	import pcpl_pkg::*;
;
	typedef struct packed {
		logic [3:0]  op;
		logic [15:0] arg;
		logic [15:0] pc;
		logic [7:0]  lat;
		logic [7:0]  low;
	} pcpl_row_t;
	// Chained from reset; stack pairs calls with the later returns
	localparam pcpl_row_t ROWS [13] = '{
		'{4'h0, 16'h0000, 16'h0001, 8'h00, 8'h00}, '{4'h1, 16'h0000, 16'h0002, 8'h00, 8'h00},
		'{4'h2, 16'h1ABC, 16'h1ABC, 8'h1A, 8'h00}, '{4'h4, 16'h0055, 16'h1A55, 8'h1A, 8'h00},
		'{4'h3, 16'h0123, 16'h0123, 8'h01, 8'h00}, '{4'h5, 16'h0000, 16'h1A55, 8'h01, 8'h00},
		'{4'h9, 16'h0000, 16'h1A56, 8'h1A, 8'h55}, '{4'hA, 16'h0077, 16'h1A77, 8'h1A, 8'h55},
		'{4'h8, 16'h0000, `PCPL_IRQ_VECTOR, 8'h1A, 8'h55},
		'{4'hB, 16'h0040, 16'h1A40, 8'h1A, 8'h20}, '{4'h7, 16'h0000, 16'h1A77, 8'h1A, 8'h20},
		'{4'h6, 16'h0000, 16'h1ABC, 8'h1A, 8'h20}, '{4'hC, 16'h0000, 16'h1ABD, 8'h1A, 8'h20}};
	logic        clock_i, rst_i, req, done, cmd_v, cmd_r, fcp, seen;
	pcpl_cmd_t   req_cmd, cmd;
	logic [7:0]  aw_a, ar_a, lat, low;
	logic [31:0] w_d, r_d, d;
	logic [15:0] pc;
	logic [1:0]  b_resp, r_resp, r;
	logic        aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
	int          n_errors, compares;
	logic [3:0]  pulses;
	pcpl_program_counter #(.IRQ_VECTOR(`PCPL_IRQ_VECTOR)) dut_u (.clock_i(clock_i),
		.rst_i(rst_i), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
		.s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
		.s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a),
		.s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_resp),
		.s_axi_rvalid(r_v), .s_axi_rready(r_r), .cmd_valid_i(cmd_v), .cmd_i(cmd),
		.cmd_ready_o(cmd_r), .pc_o(pc), .high_byte_holding_latch_o(lat),
		.low_read_data_o(low), .first_cycle_phase_o(fcp));
	pcpl_decoder_model dec_u (.clock_i(clock_i), .rst_i(rst_i), .req_i(req),
		.req_cmd_i(req_cmd), .cmd_ready_i(cmd_r), .cmd_valid_o(cmd_v), .cmd_o(cmd),
		.done_o(done));
	// ------
	// Checking and bus tasks
	// ------
	task automatic final_report();
		if (n_errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [39:0] s, input logic [39:0] e);
		compares++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic hang();
		n_errors++;
		final_report();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock_i);
		{aw_a, w_d, aw_v, w_v, b_r} <= {a, v, 3'b111};
		repeat (40) begin
			@(posedge clock_i);
			if (aw_r === 1'b1)
				aw_v <= 1'b0;
			if (w_r === 1'b1)
				w_v <= 1'b0;
			if (b_v === 1'b1) begin
				r = b_resp;
				b_r <= 1'b0;
				return;
			end
		end
		hang();
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clock_i);
		{ar_a, ar_v, r_r} <= {a, 2'b11};
		repeat (40) begin
			@(posedge clock_i);
			if (ar_r === 1'b1)
				ar_v <= 1'b0;
			if (r_v === 1'b1) begin
				{d, r} = {r_d, r_resp};
				r_r <= 1'b0;
				return;
			end
		end
		hang();
	endtask
	task automatic do_cmd(input logic [3:0] op, input logic [15:0] arg);
		@(posedge clock_i);
		req_cmd <= '{pcpl_op_t'(op), arg, arg[7:0]};
		req     <= 1'b1;
		@(posedge clock_i);
		req <= 1'b0;
		repeat (20) begin
			@(posedge clock_i);
			if (done === 1'b1)
				return;
		end
		hang();
	endtask
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	// ------
	// Main sequence
	// ------
	initial begin
		{rst_i, req, req_cmd, aw_a, ar_a, w_d, aw_v, w_v, b_r, ar_v, r_r} = '0;
		rst_i = 1'b1;
		repeat (8) @(posedge clock_i);
		rst_i <= 1'b0;
		chk("reset", {pc, lat, low}, 32'h0);
		rd(`PCPL_REG_CTRL);
		chk("ctrl", d, 32'h1);
		foreach (ROWS[i]) begin
			do_cmd(ROWS[i].op, ROWS[i].arg);
			chk("pc", pc, ROWS[i].pc);
			chk("latch", lat, ROWS[i].lat);
			chk("low", low, ROWS[i].low);
		end
		wr(`PCPL_REG_LATCH, 32'h55);
		rd(`PCPL_REG_LOW);
		chk("low reg", d, 32'hBD);
		chk("latch", lat, 8'h1A);
		wr(`PCPL_REG_LATCH, 32'hE5);
		wr(`PCPL_REG_LOW, 32'h10);
		chk("pc", pc, 16'hE510);
		do_cmd(4'h2, 16'h0345);
		chk("pc", {pc, lat}, 24'hE345E3);
		wr(`PCPL_REG_PC, 32'h1234);
		chk("pc write resp", r, `PCPL_RESP_OKAY);
		rd(`PCPL_REG_PC);
		chk("pc reg", {d, r}, {32'h0000E345, `PCPL_RESP_OKAY});
		rd(8'h10);
		chk("unmapped", {d, r}, {32'h0, `PCPL_RESP_SLVERR});
		wr(8'h10, 32'h0);
		chk("unmapped write", r, `PCPL_RESP_SLVERR);
		wr(`PCPL_REG_CTRL, 32'h0);
		seen = 1'b0;
		repeat (8) begin
			@(posedge clock_i);
			seen = seen | cmd_r | fcp;
		end
		chk("stopped", {seen, pc}, {1'b0, 16'hE345});
		wr(`PCPL_REG_CTRL, 32'h1);
		// Any eight edges while running hold exactly two first-phase strobes
		pulses = 4'h0;
		repeat (8) begin
			@(posedge clock_i);
			pulses = pulses + {3'b000, fcp};
		end
		chk("fetch strobes", pulses, 4'h2);
		rst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		do_cmd(4'h0, 16'h0000);
		chk("after reset", {pc, lat, low}, 32'h00010000);
		final_report();
	end
endmodule
